// ===== rtl/bls_map.svh
`ifndef BLS_MAP_SVH
`define BLS_MAP_SVH

// register select codes on the register transfer port
`define BLS_SEL_LC0     3'h0
`define BLS_SEL_LC1     3'h1
`define BLS_SEL_LT0     3'h2
`define BLS_SEL_LT1     3'h3
`define BLS_SEL_LB0     3'h4
`define BLS_SEL_LB1     3'h5

// reset values
`define BLS_LOOP_RST    32'h0000_0000
`define BLS_CC_RST      1'b0

// branch costs in core clock cycles
`define BLS_COST_NT     4'h0
`define BLS_COST_TAKEN  4'h4
`define BLS_COST_MISS   4'h8
// stage distance from address-calc to second execute
`define BLS_EX2_DEPTH   4
// size of a conditional jump in bytes
`define BLS_BR_LEN      32'h0000_0002
// loop hardware re-initialisation penalty
`define BLS_REPLAY_CYC  4'hA
// least count that still loops back
`define BLS_LOOP_MIN    32'h0000_0002
`define BLS_ONE         32'h0000_0001

`endif

// ===== rtl/bls_pkg.sv
package bls_pkg;

	typedef enum logic [3:0] {
		BLS_CMP_EQ   = 4'h0,
		BLS_CMP_LT   = 4'h1,
		BLS_CMP_LE   = 4'h2,
		BLS_CMP_LTU  = 4'h3,
		BLS_CMP_LEU  = 4'h4,
		BLS_BIT_TEST = 4'h5,
		BLS_FROM_ST  = 4'h6,
		BLS_TO_ST    = 4'h7,
		BLS_ROT_L    = 4'h8,
		BLS_ROT_R    = 4'h9,
		BLS_XOR_RED  = 4'hA,
		BLS_TEST_SET = 4'hB
	} bls_cc_op_e;

	// condition flag request from the execution stage
	typedef struct packed {
		logic        valid;
		bls_cc_op_e  op;
		logic        use_imm;
		logic [2:0]  imm3;
		logic [4:0]  bit_sel;
		logic        status_in;
		logic [31:0] opa;
		logic [31:0] opb;
	} bls_cc_req_s;

	// branch in flight between address-calc and second execute
	typedef struct packed {
		logic        valid;
		logic        pred;
		logic        sense;
		logic [31:0] target;
		logic [31:0] fall;
	} bls_br_s;

	typedef enum logic [1:0] {
		BLS_RUN    = 2'b00,
		BLS_REPLAY = 2'b01
	} bls_state_e;

endpackage

// ===== rtl/bls_sequencer.sv
`timescale 1ns/100ps
`include "bls_map.svh"

// Contract
// [RULE1] 3-bit immediate compares, signed or unsigned
// [RULE2] equal, less, less-equal register compares
// [RULE3] bit test loads flag from bit
// [RULE4] sense bit selects branch on one/zero
// [RULE5] target is pc plus even 11-bit offset
// [RULE6] static predict, check in second execute
// [RULE7] cost zero, four or eight cycles
// [RULE8] unconditional target out at data-fetch, four cycles
// [RULE9] conditional move only when flag matches sense
// [RULE10] two loop units, count top bottom
// [RULE11] at bottom address jump to top
// [RULE12] decrement nonzero count, loop if two+
// [RULE13] loop setup loads all three, pc-relative
// [RULE14] top offset 5-bit signed even (code zero-extends it: 0 to 30 bytes forward)
// [RULE15] bottom offset 11-bit signed even (code zero-extends it: 0 to 2046 bytes forward)
// [RULE16] loop counts are unsigned 32-bit
// [RULE17] zero count means loop inactive
// [RULE18] single writes allowed, active unit replays
// [RULE19] flag loads from and stores to status
// [RULE20] rotate and xor use flag
// [RULE21] test-and-set drives flag from memory
// [RULE22] discarded speculative fetch possible, software syncs
// [RULE23] unit 1 loopback beats unit 0
module bls_sequencer #(
	parameter int AW = 32
) (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                sys_rst,
	// condition flag requests
	input  wire bls_pkg::bls_cc_req_s cc_req,
	output logic                     condition_flag_q,
	output logic                     status_wr_q,
	output logic                     status_val_q,
	output logic [31:0]              shift_result_q,
	// branch from address-calc stage
	input  wire logic                br_valid,
	input  wire logic                br_cond,
	input  wire logic                br_sense,
	input  wire logic                br_pred,
	input  wire logic [AW-1:0]       br_pc,
	input  wire logic [10:0]         br_off,
	output logic                     fetch_redirect_q,
	output logic [AW-1:0]            fetch_addr_q,
	output logic [3:0]               br_cost_q,
	// conditional register move
	input  wire logic                cmov_valid,
	input  wire logic                cmov_sense,
	input  wire logic [3:0]          cmov_dst,
	input  wire logic [31:0]         cmov_data,
	output logic                     cmov_we_q,
	output logic [3:0]               cmov_dst_q,
	output logic [31:0]              cmov_data_q,
	// loop setup instruction
	input  wire logic                loop_setup_instruction_valid,
	input  wire logic                loop_setup_instruction_unit,
	input  wire logic [AW-1:0]       loop_setup_instruction_pc,
	input  wire logic [4:0]          loop_setup_instruction_top_off,
	input  wire logic [10:0]         loop_setup_instruction_bot_off,
	input  wire logic [31:0]         loop_setup_instruction_count,
	// executing instruction
	input  wire logic                exec_valid,
	input  wire logic [AW-1:0]       exec_pc,
	output logic                     loop_back_q,
	output logic [AW-1:0]            loop_addr_q,
	// loop register transfers
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire logic [2:0]          reg_sel,
	input  wire logic [31:0]         reg_wdata,
	output logic [31:0]              reg_rdata_q,
	output logic                     replay_busy_q
);

	// ----------------------------------------------------------
	// condition flag
	// ----------------------------------------------------------
	logic [31:0] cmp_b;
	logic        cc_d;
	logic [31:0] shift_d;
	logic        st_wr_d;

	always_comb begin
		// [RULE1] immediate sign or zero extend
		if (!cc_req.use_imm)
			cmp_b = cc_req.opb;
		else if (cc_req.op == bls_pkg::BLS_CMP_LTU ||
			cc_req.op == bls_pkg::BLS_CMP_LEU)
			cmp_b = {29'h0, cc_req.imm3};
		else
			cmp_b = {{29{cc_req.imm3[2]}}, cc_req.imm3};
	end

	always_comb begin
		cc_d    = condition_flag_q;
		shift_d = shift_result_q;
		st_wr_d = 1'b0;
		case (cc_req.op)
			// [RULE2] register pair compares
			bls_pkg::BLS_CMP_EQ: cc_d = cc_req.opa == cmp_b;
			bls_pkg::BLS_CMP_LT:
				cc_d = $signed(cc_req.opa) < $signed(cmp_b);
			bls_pkg::BLS_CMP_LE:
				cc_d = $signed(cc_req.opa) <= $signed(cmp_b);
			bls_pkg::BLS_CMP_LTU: cc_d = cc_req.opa < cmp_b;
			bls_pkg::BLS_CMP_LEU: cc_d = cc_req.opa <= cmp_b;
			// [RULE3] selected bit into flag
			bls_pkg::BLS_BIT_TEST:
				cc_d = cc_req.opa[cc_req.bit_sel];
			// [RULE19] status bit transfers
			bls_pkg::BLS_FROM_ST: cc_d = cc_req.status_in;
			bls_pkg::BLS_TO_ST: st_wr_d = 1'b1;
			// [RULE20] rotate through flag
			bls_pkg::BLS_ROT_L: begin
				shift_d = {cc_req.opa[30:0], condition_flag_q};
				cc_d    = cc_req.opa[31];
			end
			bls_pkg::BLS_ROT_R: begin
				shift_d = {condition_flag_q, cc_req.opa[31:1]};
				cc_d    = cc_req.opa[0];
			end
			// [RULE20] xor reduce with flag
			bls_pkg::BLS_XOR_RED: begin
				cc_d    = condition_flag_q ^
					(^(cc_req.opa & cc_req.opb));
				shift_d = {cc_req.opa[30:0], cc_d};
			end
			// [RULE21] flag set when location was clear
			bls_pkg::BLS_TEST_SET: cc_d = cc_req.opa[7:0] == 8'h00;
			default: cc_d = condition_flag_q;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			condition_flag_q <= `BLS_CC_RST;
			shift_result_q   <= 32'h0000_0000;
			status_wr_q      <= 1'b0;
			status_val_q     <= 1'b0;
		end else begin
			status_wr_q <= cc_req.valid & st_wr_d;
			if (cc_req.valid) begin
				condition_flag_q <= cc_d;
				shift_result_q   <= shift_d;
				status_val_q     <= condition_flag_q;
			end
		end
	end

	// ----------------------------------------------------------
	// branches
	// ----------------------------------------------------------
	bls_pkg::bls_br_s br_in;
	bls_pkg::bls_br_s pipe_q [`BLS_EX2_DEPTH];
	logic             ex2_taken;
	logic             ex2_miss;

	always_comb begin
		// [RULE6] both predictions travel to second execute
		br_in.valid  = br_valid & br_cond;
		br_in.pred   = br_pred;
		br_in.sense  = br_sense;
		// [RULE5] pc plus sign extended even offset
		br_in.target = br_pc + {{(AW-11){br_off[10]}},
			br_off[10:1], 1'b0};
		br_in.fall   = br_pc + AW'(`BLS_BR_LEN);
	end

	// conditional branches walk to the second execute stage
	genvar gi;
	generate
		for (gi = 0; gi < `BLS_EX2_DEPTH; gi++) begin : g_pipe
			bls_pkg::bls_br_s stage_in;
			if (gi == 0) begin : g_head
				assign stage_in = br_in;
			end else begin : g_tail
				assign stage_in = pipe_q[gi-1];
			end
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst)
					pipe_q[gi] <= '0;
				else if (ex2_miss)
					pipe_q[gi] <= '0;
				else
					pipe_q[gi] <= stage_in;
			end
		end
	endgenerate

	// [RULE4] sense picks flag one or zero
	assign ex2_taken = condition_flag_q == pipe_q[`BLS_EX2_DEPTH-1].sense;
	// [RULE6] actual flag against prediction
	assign ex2_miss  = pipe_q[`BLS_EX2_DEPTH-1].valid &
		(ex2_taken != pipe_q[`BLS_EX2_DEPTH-1].pred);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fetch_redirect_q <= 1'b0;
			fetch_addr_q     <= '0;
			br_cost_q        <= `BLS_COST_NT;
		end else if (ex2_miss) begin
			// [RULE7] misprediction costs eight
			fetch_redirect_q <= 1'b1;
			fetch_addr_q     <= ex2_taken ?
				pipe_q[`BLS_EX2_DEPTH-1].target :
				pipe_q[`BLS_EX2_DEPTH-1].fall;
			br_cost_q        <= `BLS_COST_MISS;
		end else if (br_valid & (~br_cond | br_pred)) begin
			// [RULE8] target driven at first data fetch
			fetch_redirect_q <= 1'b1;
			fetch_addr_q     <= br_in.target;
			br_cost_q        <= `BLS_COST_TAKEN;
		end else begin
			// [RULE22] speculative fetch is not withdrawn
			fetch_redirect_q <= 1'b0;
			br_cost_q        <= `BLS_COST_NT;
		end
	end

	// ----------------------------------------------------------
	// conditional move
	// ----------------------------------------------------------
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmov_we_q   <= 1'b0;
			cmov_dst_q  <= 4'h0;
			cmov_data_q <= 32'h0000_0000;
		end else begin
			// [RULE9] write only on matching flag
			cmov_we_q   <= cmov_valid &
				(condition_flag_q == cmov_sense);
			cmov_dst_q  <= cmov_dst;
			cmov_data_q <= cmov_data;
		end
	end

	// ----------------------------------------------------------
	// loop units
	// ----------------------------------------------------------
	// [RULE10] two units of three registers
	// [RULE16] unsigned count
	logic [31:0]   lc_q [2];
	logic [AW-1:0] lt_q [2];
	logic [AW-1:0] lb_q [2];
	logic [1:0]    at_end;
	logic [1:0]    do_loop;
	logic          reinit;
	logic [AW-1:0] set_top;
	logic [AW-1:0] set_bot;

	generate
		for (gi = 0; gi < 2; gi++) begin : g_end
			// [RULE17] zero count never matches
			assign at_end[gi] = exec_valid & (exec_pc == lb_q[gi]) &
				(lc_q[gi] != 32'h0);
		end
	endgenerate

	// [RULE12] loop back only from two or more
	// [RULE23] unit 1 loopback masks unit 0
	assign do_loop[1] = at_end[1] & (lc_q[1] >= `BLS_LOOP_MIN);
	assign do_loop[0] = at_end[0] & ~do_loop[1] &
		(lc_q[0] >= `BLS_LOOP_MIN);

	// [RULE14] top offset, even, 0 to 30 bytes forward
	assign set_top = loop_setup_instruction_pc + {{(AW-5){1'b0}},
		loop_setup_instruction_top_off[4:1], 1'b0};
	// [RULE15] bottom offset, even, 0 to 2046 bytes forward
	assign set_bot = loop_setup_instruction_pc + {{(AW-11){1'b0}},
		loop_setup_instruction_bot_off[10:1], 1'b0};

	// [RULE18] active unit or any count write replays
	always_comb begin
		reinit = 1'b0;
		if (reg_wr) begin
			case (reg_sel)
				`BLS_SEL_LC0, `BLS_SEL_LC1: reinit = 1'b1;
				`BLS_SEL_LT0, `BLS_SEL_LB0: reinit = lc_q[0] != 32'h0;
				`BLS_SEL_LT1, `BLS_SEL_LB1: reinit = lc_q[1] != 32'h0;
				default: reinit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 2; i++) begin
				lc_q[i] <= `BLS_LOOP_RST;
				lt_q[i] <= '0;
				lb_q[i] <= '0;
			end
		end else begin
			// [RULE12] nonzero count steps down at the end, except unit 0 while unit 1 loops back
			if (at_end[1])
				lc_q[1] <= lc_q[1] - `BLS_ONE;
			if (at_end[0] & ~do_loop[1])
				lc_q[0] <= lc_q[0] - `BLS_ONE;
			// [RULE13] setup loads all three at once
			if (loop_setup_instruction_valid) begin
				lc_q[loop_setup_instruction_unit] <= loop_setup_instruction_count;
				lt_q[loop_setup_instruction_unit] <= set_top;
				lb_q[loop_setup_instruction_unit] <= set_bot;
			end
			// [RULE18] single register transfers
			if (reg_wr) begin
				case (reg_sel)
					`BLS_SEL_LC0: lc_q[0] <= reg_wdata;
					`BLS_SEL_LC1: lc_q[1] <= reg_wdata;
					`BLS_SEL_LT0: lt_q[0] <= reg_wdata[AW-1:0];
					`BLS_SEL_LT1: lt_q[1] <= reg_wdata[AW-1:0];
					`BLS_SEL_LB0: lb_q[0] <= reg_wdata[AW-1:0];
					`BLS_SEL_LB1: lb_q[1] <= reg_wdata[AW-1:0];
					default: lc_q[0] <= lc_q[0];
				endcase
			end
		end
	end

	// [RULE11] next instruction from loop top
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			loop_back_q <= 1'b0;
			loop_addr_q <= '0;
		end else begin
			loop_back_q <= do_loop[1] | do_loop[0];
			loop_addr_q <= do_loop[1] ? lt_q[1] : lt_q[0];
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_q <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_sel)
				`BLS_SEL_LC0: reg_rdata_q <= lc_q[0];
				`BLS_SEL_LC1: reg_rdata_q <= lc_q[1];
				`BLS_SEL_LT0: reg_rdata_q <= 32'(lt_q[0]);
				`BLS_SEL_LT1: reg_rdata_q <= 32'(lt_q[1]);
				`BLS_SEL_LB0: reg_rdata_q <= 32'(lb_q[0]);
				`BLS_SEL_LB1: reg_rdata_q <= 32'(lb_q[1]);
				default: reg_rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------
	// loop hardware replay
	// ----------------------------------------------------------
	bls_pkg::bls_state_e state_q;
	logic [3:0]          replay_cnt_q;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q       <= bls_pkg::BLS_RUN;
			replay_cnt_q  <= 4'h0;
			replay_busy_q <= 1'b0;
		end else begin
			case (state_q)
				bls_pkg::BLS_RUN: begin
					if (reinit) begin
						state_q       <= bls_pkg::BLS_REPLAY;
						replay_cnt_q  <= `BLS_REPLAY_CYC - 4'h1;
						replay_busy_q <= 1'b1;
					end
				end
				bls_pkg::BLS_REPLAY: begin
					if (reinit) begin
						replay_cnt_q <= `BLS_REPLAY_CYC - 4'h1;
					end else if (replay_cnt_q == 4'h0) begin
						state_q       <= bls_pkg::BLS_RUN;
						replay_cnt_q  <= 4'h0;
						replay_busy_q <= 1'b0;
					end else begin
						replay_cnt_q <= replay_cnt_q - 4'h1;
					end
				end
				default: begin
					state_q       <= bls_pkg::BLS_RUN;
					replay_busy_q <= 1'b0;
				end
			endcase
		end
	end

endmodule

// ===== dv/bls_seq_monitor.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checker for the sequencer
// ----------------------------------------
module bls_seq_monitor #(
	parameter int AW = 32
) (
	// clock and reset
	input wire logic                 ref_clk,
	input wire logic                 sys_rst,
	// flag path
	input wire bls_pkg::bls_cc_req_s cc_req,
	input wire logic                 condition_flag_q,
	input wire logic                 status_wr_q,
	input wire logic                 status_val_q,
	input wire logic [31:0]          shift_result_q,
	// branch path
	input wire logic                 br_valid,
	input wire logic                 br_cond,
	input wire logic                 br_pred,
	input wire logic [AW-1:0]        br_pc,
	input wire logic [10:0]          br_off,
	input wire logic                 fetch_redirect_q,
	input wire logic [AW-1:0]        fetch_addr_q,
	input wire logic [3:0]           br_cost_q,
	// moves and loop registers
	input wire logic                 cmov_valid,
	input wire logic                 cmov_sense,
	input wire logic                 cmov_we_q,
	input wire logic                 reg_wr,
	input wire logic [2:0]           reg_sel,
	input wire logic                 replay_busy_q
);
	logic [AW-1:0] off_ext;
	logic          sel_bit;
	logic          low_zero;
	assign off_ext  = AW'(signed'({br_off[10:1], 1'b0}));
	assign sel_bit  = cc_req.opa[cc_req.bit_sel];
	assign low_zero = (cc_req.opa[7:0] == 8'h00);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	a_uncond_redirect: assert property (
		br_valid && (!br_cond || br_pred) |=> fetch_redirect_q &&
		(br_cost_q == 4'h8 || (br_cost_q == 4'h4 &&
		fetch_addr_q == $past(br_pc) + $past(off_ext))))
		else $error("redirect target or cost wrong");
	a_cost_values: assert property (
		(fetch_redirect_q || br_cost_q != 4'h0) |->
		fetch_redirect_q && (br_cost_q == 4'h4 || br_cost_q == 4'h8))
		else $error("branch cost out of range");
	a_cmov_sense: assert property (
		cmov_valid |=>
		cmov_we_q == ($past(condition_flag_q) == $past(cmov_sense)))
		else $error("move enable ignores sense");
	a_bit_test: assert property (
		cc_req.valid && cc_req.op == bls_pkg::BLS_BIT_TEST |=>
		condition_flag_q == $past(sel_bit))
		else $error("bit test flag wrong");
	a_test_set: assert property (
		cc_req.valid && cc_req.op == bls_pkg::BLS_TEST_SET |=>
		condition_flag_q == $past(low_zero))
		else $error("test and set flag wrong");
	a_status_store: assert property (
		cc_req.valid && cc_req.op == bls_pkg::BLS_TO_ST |=>
		status_wr_q && status_val_q == $past(condition_flag_q))
		else $error("status store wrong");
	a_rot_left: assert property (
		cc_req.valid && cc_req.op == bls_pkg::BLS_ROT_L |=>
		shift_result_q ==
		{$past(cc_req.opa[30:0]), $past(condition_flag_q)})
		else $error("rotate result wrong");
	a_replay_hold: assert property (
		reg_wr && reg_sel <= 3'h1 |=> replay_busy_q [*8] ##1 replay_busy_q [*2])
		else $error("replay shorter than ten cycles");
endmodule

bind bls_sequencer bls_seq_monitor #(.AW(AW)) i_mon (
	.ref_clk, .sys_rst, .cc_req, .condition_flag_q, .status_wr_q,
	.status_val_q, .shift_result_q, .br_valid, .br_cond, .br_pred, .br_pc,
	.br_off, .fetch_redirect_q, .fetch_addr_q, .br_cost_q, .cmov_valid,
	.cmov_sense, .cmov_we_q, .reg_wr, .reg_sel, .replay_busy_q
);

// ===== dv/bls_fetch_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// fetch and execute stage model
// ----------------------------------------
module bls_fetch_model (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// run control
	input  wire logic        run,
	input  wire logic [31:0] start_pc,
	// sequencer answers
	input  wire logic        loop_back_q,
	input  wire logic [31:0] loop_addr_q,
	// executing instruction
	output logic             exec_valid,
	output logic [31:0]      exec_pc
);
	logic [31:0] pc_q;
	logic        wait_q;
	// follows loop answer, drops the linear fetch
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pc_q   <= 32'h0000_0000;
			wait_q <= 1'b0;
		end else if (!run) begin
			pc_q   <= start_pc;
			wait_q <= 1'b0;
		end else begin
			wait_q <= !wait_q;
			if (wait_q)
				pc_q <= loop_back_q ? loop_addr_q : pc_q + 32'h0000_0002;
		end
	end
	// pc bus is not held between instructions
	assign exec_valid = run && !wait_q;
	assign exec_pc    = exec_valid ? pc_q : ~pc_q;
endmodule

// ===== dv/bls_sequencer_tb.sv
`timescale 1ns/100ps
`include "bls_map.svh"
module bls_sequencer_tb;
	logic ref_clk = '0, sys_rst = '1, run = '0;
	bls_pkg::bls_cc_req_s cc_req = '0;
	logic br_valid = '0, br_cond = '0, br_sense = '0, br_pred = '0;
	logic [31:0] br_pc = '0, start_pc = '0, loop_setup_instruction_pc = '0;
	logic [10:0] br_off = '0, loop_setup_instruction_bot_off = '0;
	logic cmov_valid = '0, cmov_sense = '0, loop_setup_instruction_valid = '0;
	logic [3:0] cmov_dst = '0;
	logic [31:0] cmov_data = '0, loop_setup_instruction_count = '0, reg_wdata = '0;
	logic loop_setup_instruction_unit = '0, reg_wr = '0, reg_rd = '0, seen;
	logic [4:0] loop_setup_instruction_top_off = '0;
	logic [2:0] reg_sel = '0;
	logic condition_flag_q, status_wr_q, status_val_q, fetch_redirect_q;
	logic cmov_we_q, loop_back_q, replay_busy_q, exec_valid;
	logic [31:0] shift_result_q, fetch_addr_q, cmov_data_q, loop_addr_q;
	logic [31:0] reg_rdata_q, exec_pc, lb_exp;
	logic [3:0] br_cost_q, cmov_dst_q;
	int error_cnt = 0, num_checks = 0, cyc = 0, lb_cnt = 0;

	bls_sequencer i_dut (.ref_clk, .sys_rst, .cc_req, .condition_flag_q,
		.status_wr_q, .status_val_q, .shift_result_q, .br_valid, .br_cond,
		.br_sense, .br_pred, .br_pc, .br_off, .fetch_redirect_q, .fetch_addr_q,
		.br_cost_q, .cmov_valid, .cmov_sense, .cmov_dst, .cmov_data, .cmov_we_q,
		.cmov_dst_q, .cmov_data_q, .loop_setup_instruction_valid, .loop_setup_instruction_unit, .loop_setup_instruction_pc,
		.loop_setup_instruction_top_off, .loop_setup_instruction_bot_off, .loop_setup_instruction_count, .exec_valid, .exec_pc,
		.loop_back_q, .loop_addr_q, .reg_wr, .reg_rd, .reg_sel, .reg_wdata,
		.reg_rdata_q, .replay_busy_q);
	bls_fetch_model i_model (.ref_clk, .sys_rst, .run, .start_pc,
		.loop_back_q, .loop_addr_q, .exec_valid, .exec_pc);

	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			give_verdict();
		end
		if (loop_back_q === 1'b1) begin
			lb_cnt++;
			check(loop_addr_q, lb_exp);
		end
	end

	task automatic step(input int n = 1);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h want %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic reg_write(input logic [2:0] s, input logic [31:0] d);
		step();
		{reg_sel, reg_wdata, reg_wr} = {s, d, 1'b1};
		step();
		reg_wr = 1'b0;
	endtask
	task automatic reg_read(input logic [2:0] s, input logic [31:0] exp);
		step();
		{reg_sel, reg_rd} = {s, 1'b1};
		step();
		reg_rd = 1'b0;
		check(reg_rdata_q, exp);
	endtask
	task automatic cc(input bls_pkg::bls_cc_op_e op, input logic [3:0] i,
			input logic [31:0] a, b, input logic exp);
		step();
		cc_req = '{1'b1, op, i[3], i[2:0], b[4:0], b[0], a, b};
		step();
		cc_req.valid = 1'b0;
		check(condition_flag_q, exp);
	endtask
	task automatic branch(input logic [2:0] csp, input logic [31:0] pc,
			input logic [10:0] off, input logic r, input logic [31:0] a);
		step();
		{br_cond, br_sense, br_pred, br_pc, br_off} = {csp, pc, off};
		br_valid = 1'b1;
		step();
		br_valid = 1'b0;
		check(fetch_redirect_q, r);
		if (r)
			check(fetch_addr_q, a);
	endtask
	task automatic loop_setup_instruction(input logic u, input logic [31:0] pc,
			input logic [4:0] t, input logic [10:0] b, input logic [31:0] n);
		step();
		{loop_setup_instruction_unit, loop_setup_instruction_pc, loop_setup_instruction_top_off} = {u, pc, t};
		{loop_setup_instruction_bot_off, loop_setup_instruction_count, loop_setup_instruction_valid} = {b, n, 1'b1};
		step();
		loop_setup_instruction_valid = 1'b0;
	endtask
	task automatic run_from(input logic [31:0] pc, input int n);
		start_pc = pc;
		step();
		run = 1'b1;
		step(n);
		run = 1'b0;
	endtask

	initial begin
		step(20);
		sys_rst = 1'b0;
		for (int s = 0; s < 6; s++)
			reg_read(3'(s), 32'h0);
		for (int s = 0; s < 6; s++)
			reg_write(3'(s), 32'hFFFF_FFF0 + 32'(s));
		for (int s = 0; s < 7; s++)
			reg_read(3'(s), s < 6 ? 32'hFFFF_FFF0 + 32'(s) : 32'h0);
		reg_write(`BLS_SEL_LC0, 32'h0);
		reg_write(`BLS_SEL_LC1, 32'h0);
		check(replay_busy_q, 1'b1);
		step(9);
		check(replay_busy_q, 1'b1);
		step();
		check(replay_busy_q, 1'b0);
		reg_write(`BLS_SEL_LT0, 32'h4);
		check(replay_busy_q, 1'b0);
		$display("test registers done");
		cc(bls_pkg::BLS_CMP_LT, 4'hC, 32'hFFFF_FFFB, 32'h0, 1'b1);
		cc(bls_pkg::BLS_CMP_LE, 4'hB, 32'h3, 32'h0, 1'b1);
		cc(bls_pkg::BLS_CMP_LTU, 4'hF, 32'h6, 32'h0, 1'b1);
		cc(bls_pkg::BLS_CMP_LEU, 4'hF, 32'h8, 32'h0, 1'b0);
		cc(bls_pkg::BLS_CMP_EQ, 4'h0, 32'h5, 32'h5, 1'b1);
		cc(bls_pkg::BLS_CMP_LT, 4'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
		cc(bls_pkg::BLS_CMP_LE, 4'h0, 32'h2, 32'h1, 1'b0);
		cc(bls_pkg::BLS_BIT_TEST, 4'h0, 32'h8000_0000, 32'h1F, 1'b1);
		cc(bls_pkg::BLS_TEST_SET, 4'h0, 32'h1, 32'h0, 1'b0);
		cc(bls_pkg::BLS_TEST_SET, 4'h0, 32'h100, 32'h0, 1'b1);
		cc(bls_pkg::BLS_FROM_ST, 4'h0, 32'h0, 32'h1, 1'b1);
		cc(bls_pkg::BLS_TO_ST, 4'h0, 32'h0, 32'h0, 1'b1);
		check({status_wr_q, status_val_q}, 2'b11);
		cc(bls_pkg::BLS_ROT_L, 4'h0, 32'h8000_0001, 32'h0, 1'b1);
		check(shift_result_q, 32'h3);
		cc(bls_pkg::BLS_ROT_R, 4'h0, 32'h3, 32'h0, 1'b1);
		check(shift_result_q, 32'h8000_0001);
		cc(bls_pkg::BLS_XOR_RED, 4'h0, 32'h3, 32'h1, 1'b0);
		check(shift_result_q, 32'h6);
		{cmov_dst, cmov_data} = {4'h5, 32'h0000_00A5};
		{cmov_sense, cmov_valid} = 2'b01;
		step();
		{cmov_sense, cmov_valid} = 2'b11;
		check(cmov_data_q, 32'h0000_00A5);
		check(32'(cmov_dst_q), 32'h5);
		check(cmov_we_q, 1'b1);
		step();
		cmov_valid = 1'b0;
		check(cmov_we_q, 1'b0);
		$display("test flag done");
		branch(3'b000, 32'h1000, 11'h400, 1'b1, 32'h0C00);
		check(br_cost_q, `BLS_COST_TAKEN);
		branch(3'b000, 32'h1000, 11'h3FF, 1'b1, 32'h13FE);
		branch(3'b101, 32'h2000, 11'h010, 1'b1, 32'h2010);
		check(br_cost_q, `BLS_COST_TAKEN);
		branch(3'b100, 32'h2000, 11'h010, 1'b0, 32'h0);
		step(3);
		check(fetch_redirect_q, 1'b0);
		step();
		check({fetch_redirect_q, br_cost_q}, 5'h18);
		check(fetch_addr_q, 32'h2010);
		branch(3'b111, 32'h2000, 11'h010, 1'b1, 32'h2010);
		step(3);
		check(fetch_redirect_q, 1'b0);
		step();
		check({fetch_redirect_q, br_cost_q}, 5'h18);
		check(fetch_addr_q, 32'h2002);
		branch(3'b110, 32'h2000, 11'h010, 1'b0, 32'h0);
		seen = 1'b0;
		repeat (6) begin
			step();
			seen |= fetch_redirect_q;
		end
		check(seen, 1'b0);
		$display("test branch done");
		lb_exp = 32'h104;
		for (int n = 0; n < 4; n++) begin
			lb_cnt = 0;
			loop_setup_instruction(1'b0, 32'h100, 5'h04, 11'h008, 32'(n));
			run_from(32'h104, 24);
			check(32'(lb_cnt), n < 2 ? 32'h0 : 32'(n - 1));
			reg_read(`BLS_SEL_LC0, 32'h0);
		end
		loop_setup_instruction(1'b0, 32'h1000, 5'h1E, 11'h7FE, 32'h0);
		reg_read(`BLS_SEL_LT0, 32'h101E);
		reg_read(`BLS_SEL_LB0, 32'h17FE);
		loop_setup_instruction(1'b1, 32'h200, 5'h02, 11'h006, 32'h2);
		loop_setup_instruction(1'b0, 32'h200, 5'h00, 11'h006, 32'h2);
		lb_exp = 32'h202;
		run_from(32'h206, 2);
		reg_read(`BLS_SEL_LC0, 32'h2);
		reg_read(`BLS_SEL_LC1, 32'h1);
		$display("test loop done");
		give_verdict();
	end
endmodule
